/* File: common/wit_pkg.sv */
// Shared constants and carrier types for the watchdog / interval timer
package wit_pkg;

    // Register word indices, byte address is index * 4
    localparam logic [1:0] IDX_CTRL   = 2'h0;
    localparam logic [1:0] IDX_COUNT  = 2'h1;
    localparam logic [1:0] IDX_RSTCTL = 2'h2;

    // Write keys carried in bits 15:8 of a write word
    localparam logic [7:0] KEY_COUNT   = 8'h5a;
    localparam logic [7:0] KEY_CTRL    = 8'ha5;
    localparam logic [7:0] KEY_RST_CLR = 8'ha5;
    localparam logic [7:0] KEY_RST_CFG = 8'h5a;
    localparam logic [7:0] RST_CLR_VAL = 8'h00;

    // Field positions
    localparam int BIT_OVF        = 7;
    localparam int BIT_MODE       = 6;
    localparam int BIT_ENABLE     = 5;
    localparam int BIT_WD_FLAG    = 7;
    localparam int BIT_RESET_EN   = 6;
    localparam int BIT_RESET_TYPE = 5;

    // Reserved bits read as one; counter reset and top values
    localparam logic [7:0] CTRL_ONES = 8'h18;
    localparam logic [7:0] RST_ONES  = 8'h1f;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hff;

    // Timing in system clock states
    localparam int RESET_STATES = 518;
    localparam int BLOCK_STATES = 132;
    localparam int PRESCALE_W   = 17;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wit_wb_req_t;

    typedef struct packed {
        logic       ovf;
        logic       mode;
        logic       enable;
        logic [2:0] cks;
    } wit_ctrl_t;

endpackage

/* File: rtl/wit_timer.sv */
// Watchdog / interval timer with classic Wishbone register access
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ns

module wit_timer #(
    parameter int RESET_STATES = wit_pkg::RESET_STATES,
    parameter int BLOCK_STATES = wit_pkg::BLOCK_STATES
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Wishbone slave
    input  wire wit_pkg::wit_wb_req_t wb_req,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // External reset pin, asynchronous, active low
    input  wire logic                 external_reset_pin_n,
    // Chip reset logic and interrupt controller
    output logic                      chip_reset_req,
    output logic                      reset_is_manual,
    output logic                      interval_interrupt_request
);

    if (RESET_STATES < 2 || RESET_STATES > 1023) begin : g_chk_rst
        $error("RESET_STATES out of range");
    end
    if (BLOCK_STATES < 2 || BLOCK_STATES > 255) begin : g_chk_blk
        $error("BLOCK_STATES out of range");
    end

    localparam logic [9:0] RST_LOAD = 10'(RESET_STATES - 1);
    localparam logic [7:0] BLK_LOAD = 8'(BLOCK_STATES);

    // Low prescaler bits that must be all ones for a tick: divide by 2**k
    function automatic logic [16:0] div_mask(input logic [2:0] cks);
        case (cks)
            3'h0:    div_mask = 17'h00001;
            3'h1:    div_mask = 17'h0003f;
            3'h2:    div_mask = 17'h0007f;
            3'h3:    div_mask = 17'h001ff;
            3'h4:    div_mask = 17'h007ff;
            3'h5:    div_mask = 17'h01fff;
            3'h6:    div_mask = 17'h07fff;
            default: div_mask = 17'h1ffff;
        endcase
    endfunction

    wit_pkg::wit_ctrl_t ctrl;
    logic [7:0]         count;
    logic               wd_flag;
    logic               reset_en;
    logic               reset_type;
    logic [2:0]         pin_sync;
    logic               pin_active;
    logic [16:0]        prescale;
    logic [9:0]         rst_cnt;
    logic [7:0]         blk_cnt;
    logic               ovf_armed;
    logic               wd_flag_armed;
    logic               next_ovf;

    // Pin reset filter: change counts once the last two stages agree
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_sync   <= 3'h7;
            pin_active <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], external_reset_pin_n};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_active <= ~pin_sync[2];
            end
        end
    end

    logic hard;
    assign hard = srst | pin_active;

    // Bus decode; requests are acted on at the edge where ack is high
    logic       acc;
    logic       wr_ok;
    logic       blocked;
    logic [1:0] idx;
    logic [7:0] key;
    logic [7:0] wdat;
    assign acc     = wb_req.cyc & wb_req.stb & wb_ack_o;
    assign blocked = (blk_cnt != 8'h00);
    assign idx     = wb_req.adr[3:2];
    assign key     = wb_req.dat[15:8];
    assign wdat    = wb_req.dat[7:0];
    // Byte writes are dropped; only full low-half word writes count
    assign wr_ok   = acc & wb_req.we & (wb_req.sel[1:0] == 2'h3) & ~blocked;

    logic wr_count;
    logic wr_ctrl;
    logic wr_rclr;
    logic wr_rcfg;
    assign wr_count = wr_ok & (idx == wit_pkg::IDX_CTRL) & (key == wit_pkg::KEY_COUNT);
    assign wr_ctrl  = wr_ok & (idx == wit_pkg::IDX_CTRL) & (key == wit_pkg::KEY_CTRL);
    assign wr_rclr  = wr_ok & (idx == wit_pkg::IDX_RSTCTL) & (key == wit_pkg::KEY_RST_CLR)
                      & (wdat == wit_pkg::RST_CLR_VAL);
    assign wr_rcfg  = wr_ok & (idx == wit_pkg::IDX_RSTCTL) & (key == wit_pkg::KEY_RST_CFG);

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req.cyc & wb_req.stb & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0;
        end else if (wb_req.cyc & wb_req.stb & ~wb_ack_o) begin
            case (idx)
                wit_pkg::IDX_CTRL:   wb_dat_o <= {24'h0, ctrl.ovf, ctrl.mode, ctrl.enable,
                                                  2'h3, ctrl.cks};
                wit_pkg::IDX_COUNT:  wb_dat_o <= {24'h0, count};
                wit_pkg::IDX_RSTCTL: wb_dat_o <= {24'h0, wd_flag, reset_en, reset_type, 5'h1f};
                default:             wb_dat_o <= 32'h0;
            endcase
        end
    end

    // Free-running prescaler; one-cycle tick at the selected rate
    always_ff @(posedge clk) begin
        if (hard) begin
            prescale <= 17'h0;
        end else begin
            prescale <= prescale + 17'h1;
        end
    end

    logic tick;
    logic ovf_ev;
    logic wd_ovf;
    logic int_ovf;
    assign tick    = &(prescale | ~div_mask(ctrl.cks));
    // A write in the tick cycle replaces the increment, so no overflow
    assign ovf_ev  = tick & ctrl.enable & (count == wit_pkg::COUNT_TOP)
                     & ~wr_count & ~hard;
    assign wd_ovf  = ovf_ev & ctrl.mode;
    assign int_ovf = ovf_ev & ~ctrl.mode;

    always_ff @(posedge clk) begin
        if (hard || wd_ovf || !ctrl.enable) begin
            count <= wit_pkg::COUNT_RST;
        end else if (wr_count) begin
            count <= wdat;
        end else if (tick) begin
            count <= count + 8'h1;
        end
    end

    // Flag clears only after a read that saw it set; a new set beats the clear
    always_comb begin
        next_ovf = ctrl.ovf;
        if (wr_ctrl && !wdat[wit_pkg::BIT_OVF] && ovf_armed) begin
            next_ovf = 1'b0;
        end
        if (int_ovf) begin
            next_ovf = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (hard || wd_ovf) begin
            ctrl                       <= '0;
            interval_interrupt_request <= 1'b0;
        end else begin
            ctrl.ovf                   <= next_ovf;
            interval_interrupt_request <= next_ovf;
            if (wr_ctrl) begin
                ctrl.mode   <= wdat[wit_pkg::BIT_MODE];
                ctrl.enable <= wdat[wit_pkg::BIT_ENABLE];
                ctrl.cks    <= wdat[2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (hard || wr_ctrl) begin
            ovf_armed <= 1'b0;
        end else if (acc && !wb_req.we && idx == wit_pkg::IDX_CTRL && ctrl.ovf) begin
            ovf_armed <= 1'b1;
        end
    end

    // Reset control survives the internal reset; only srst or the pin clear it
    always_ff @(posedge clk) begin
        if (hard) begin
            wd_flag    <= 1'b0;
            reset_en   <= 1'b0;
            reset_type <= 1'b0;
        end else begin
            if (wd_ovf) begin
                wd_flag <= 1'b1;
            end else if (wr_rclr && wd_flag_armed) begin
                wd_flag <= 1'b0;
            end
            if (wr_rcfg) begin
                reset_en   <= wdat[wit_pkg::BIT_RESET_EN];
                reset_type <= wdat[wit_pkg::BIT_RESET_TYPE];
            end
        end
    end

    // Reads during the blocked window do not arm the clear
    always_ff @(posedge clk) begin
        if (hard || wr_rclr) begin
            wd_flag_armed <= 1'b0;
        end else if (acc && !wb_req.we && idx == wit_pkg::IDX_RSTCTL && wd_flag && !blocked) begin
            wd_flag_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (hard) begin
            blk_cnt <= 8'h0;
        end else if (ovf_ev) begin
            blk_cnt <= BLK_LOAD;
        end else if (blocked) begin
            blk_cnt <= blk_cnt - 8'h1;
        end
    end

    // Internal reset pulse; the pin reset cuts it short
    always_ff @(posedge clk) begin
        if (hard) begin
            rst_cnt         <= 10'h0;
            chip_reset_req  <= 1'b0;
            reset_is_manual <= 1'b0;
        end else if (wd_ovf && reset_en) begin
            rst_cnt         <= RST_LOAD;
            chip_reset_req  <= 1'b1;
            reset_is_manual <= reset_type;
        end else if (rst_cnt != 10'h0) begin
            rst_cnt <= rst_cnt - 10'h1;
        end else begin
            chip_reset_req <= 1'b0;
        end
    end

    // Length of the current reset pulse, read only by checks
    logic [9:0] hi_len;
    always_ff @(posedge clk) begin
        if (srst || !chip_reset_req) begin
            hi_len <= 10'h0;
        end else begin
            hi_len <= hi_len + 10'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_wd_reset_ovf;
        wd_ovf && reset_en;
    endsequence

    sequence s_pulse_on;
        chip_reset_req && (reset_is_manual == $past(reset_type));
    endsequence

    a_reset_type_start: assert property (s_wd_reset_ovf |=> s_pulse_on)
        else $error("watchdog overflow did not raise typed reset");
    // At the falling edge hi_len already holds the full count of high cycles
    a_reset_pulse_len: assert property ($fell(chip_reset_req) && !$past(pin_active)
        |-> hi_len == 10'(RESET_STATES))
        else $error("internal reset pulse length wrong");
    a_pin_reset_wins: assert property (pin_active |=> !chip_reset_req && !wd_flag)
        else $error("pin reset did not win");
    a_int_flag_set: assert property (int_ovf |=> ctrl.ovf && interval_interrupt_request)
        else $error("interval overflow flag or interrupt missing");
    a_wd_flag_set: assert property (wd_ovf |=> wd_flag && !interval_interrupt_request)
        else $error("watchdog flag not set");
    a_irq_follows_flag: assert property (interval_interrupt_request == ctrl.ovf)
        else $error("interrupt does not follow flag");
    a_write_beats_inc: assert property (wr_count && tick && ctrl.enable && !hard
        && !wd_ovf |=> count == $past(wdat))
        else $error("count write lost to increment");
    a_wd_soft_clear: assert property (wd_ovf && !reset_en && !pin_active
        |=> count == 8'h00 && !ctrl.enable && !ctrl.mode)
        else $error("overflow without reset left counter or control");
    // Blocked from the first to the 132nd cycle after the overflow edge
    a_block_window: assert property (ovf_ev && !pin_active ##1 !pin_active[*8]
        |-> ##124 (blocked && !pin_active) ##1 !blocked)
        else $error("write blocking window length wrong");
    a_disabled_zero: assert property (!ctrl.enable && !wr_ctrl |=> count == 8'h00)
        else $error("disabled counter not zero");
    a_cfg_key_load: assert property (wr_rcfg && !pin_active
        |=> reset_en == $past(wdat[wit_pkg::BIT_RESET_EN])
            && reset_type == $past(wdat[wit_pkg::BIT_RESET_TYPE]))
        else $error("reset control bits not loaded");

endmodule

/* File: verif/wit_reset_sink.sv */
// Chip reset logic model: measures the internal reset pulses of the timer
`timescale 1ns/1ns
module wit_reset_sink (
    // Clock
    input  wire logic clk,
    // Reset request from the timer
    input  wire logic chip_reset_req,
    input  wire logic reset_is_manual,
    // Observations
    output int        pulse_len,
    output int        pulses,
    output logic      last_manual
);
    logic req_q;

    initial begin
        req_q = 1'b0;
        pulse_len = 0;
        pulses = 0;
        last_manual = 1'b0;
    end

    always @(posedge clk) begin
        req_q <= chip_reset_req;
        if (chip_reset_req === 1'b1 && req_q !== 1'b1) begin
            // Reset type is latched where the pulse starts
            pulses      <= pulses + 1;
            pulse_len   <= 1;
            last_manual <= reset_is_manual;
        end else if (chip_reset_req === 1'b1) begin
            pulse_len <= pulse_len + 1;
        end
    end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the watchdog / interval timer
`timescale 1ns/1ns
module testbench;
    logic                 clk = 1'b0;
    logic                 srst;
    wit_pkg::wit_wb_req_t wb_req;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 pin_n;
    logic                 rst_req;
    logic                 manual;
    logic                 irq;
    int                   pulse_len;
    int                   pulses;
    logic                 last_manual;
    int                   n_errors;
    int                   comparisons;
    logic [2:0]           k;
    int                   divs [6] = '{2, 64, 128, 512, 2048, 8192};

    wit_timer i_wit_timer (
        .clk                        (clk),
        .srst                       (srst),
        .wb_req                     (wb_req),
        .wb_dat_o                   (wb_dat_o),
        .wb_ack_o                   (wb_ack_o),
        .external_reset_pin_n       (pin_n),
        .chip_reset_req             (rst_req),
        .reset_is_manual            (manual),
        .interval_interrupt_request (irq)
    );

    wit_reset_sink i_wit_reset_sink (
        .clk             (clk),
        .chip_reset_req  (rst_req),
        .reset_is_manual (manual),
        .pulse_len       (pulse_len),
        .pulses          (pulses),
        .last_manual     (last_manual)
    );

    always #4 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Called at a rising edge; holds the request until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                            input logic [31:0] dat, output logic [31:0] rd);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        // No wait-state count is assumed; only the watchdog ends a hang here
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req <= '0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] adr, input logic [7:0] key, input logic [7:0] val);
        logic [31:0] d;
        wb_cycle(1'b1, adr, 4'hf, {16'h0, key, val}, d);
    endtask

    task automatic rd_chk(input logic [3:0] adr, input logic [7:0] exp);
        logic [31:0] d;
        wb_cycle(1'b0, adr, 4'hf, 32'h0, d);
        check(d, {24'h0, exp});
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Longest test path is about 41000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial begin
        logic [31:0] d;
        srst = 1'b1;
        pin_n = 1'b1;
        wb_req = '0;
        n_errors = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk(4'h0, 8'h18);
        rd_chk(4'h4, 8'h00);
        rd_chk(4'h8, 8'h1f);
        rd_chk(4'hc, 8'h00);
        wr(4'h0, 8'h5a, 8'hf0);
        rd_chk(4'h4, 8'h00);
        wb_cycle(1'b1, 4'h0, 4'h1, 32'h0000a527, d);
        wr(4'h0, 8'h3c, 8'h27);
        wr(4'hc, 8'ha5, 8'h27);
        rd_chk(4'h0, 8'h18);
        $display("test register_access done");
        for (int c = 0; c < 6; c++) begin
            k = 3'(c);
            wr(4'h0, 8'ha5, 8'h00);
            wr(4'h0, 8'ha5, {3'b001, 2'b00, k});
            wr(4'h0, 8'h5a, 8'hff);
            for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(negedge clk);
            // Read lands mid-way between the second and third count ticks
            repeat (divs[c] * 2 + divs[c] / 2 - 1) @(posedge clk);
            rd_chk(4'h4, 8'h02);
            repeat (140) @(posedge clk);
            rd_chk(4'h0, {5'b10111, k});
            wr(4'h0, 8'ha5, {3'b001, 2'b00, k});
            @(negedge clk);
            check({31'h0, irq}, 32'h0);
            @(posedge clk);
        end
        $display("test interval_mode done");
        wr(4'h0, 8'ha5, 8'h00);
        wr(4'h8, 8'h5a, 8'h60);
        rd_chk(4'h8, 8'h7f);
        wr(4'h0, 8'ha5, 8'h60);
        wr(4'h0, 8'h5a, 8'hff);
        for (int i = 0; i < 20000 && rst_req !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        wr(4'h8, 8'h5a, 8'h00);
        for (int i = 0; i < 2000 && rst_req !== 1'b0; i++) @(negedge clk);
        check(32'(pulse_len), 32'(wit_pkg::RESET_STATES));
        check({31'h0, last_manual}, 32'h1);
        check({31'h0, irq}, 32'h0);
        @(posedge clk);
        rd_chk(4'h8, 8'hff);
        rd_chk(4'h0, 8'h18);
        wr(4'h8, 8'ha5, 8'h00);
        rd_chk(4'h8, 8'h7f);
        wr(4'h8, 8'h5a, 8'h00);
        wr(4'h0, 8'ha5, 8'h60);
        repeat (3) begin
            repeat (300) @(posedge clk);
            wr(4'h0, 8'h5a, 8'h00);
        end
        rd_chk(4'h8, 8'h1f);
        wr(4'h0, 8'h5a, 8'hff);
        repeat (200) @(posedge clk);
        check(32'(pulses), 32'h1);
        rd_chk(4'h0, 8'h18);
        rd_chk(4'h8, 8'h9f);
        rd_chk(4'h4, 8'h00);
        $display("test watchdog_mode done");
        wr(4'h8, 8'h5a, 8'h40);
        wr(4'h0, 8'ha5, 8'h60);
        wr(4'h0, 8'h5a, 8'hff);
        for (int i = 0; i < 20000 && rst_req !== 1'b1; i++) @(negedge clk);
        check({31'h0, manual}, 32'h0);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        pin_n <= 1'b1;
        repeat (8) @(posedge clk);
        check({31'h0, rst_req}, 32'h0);
        rd_chk(4'h8, 8'h1f);
        $display("test pin_reset done");
        complete_run();
    end
endmodule
